/* rtl/dpcc_regs.vh */
// register map, field layout and timing constants of the pattern/counter/clock block
// Functional notes
// R01 - changing the bank width marks every stored or captured trace invalid
// R02 - output sends 1, 2 or 4 consecutive memory bytes per handshake, ascending
// R03 - word output puts the earlier byte on data bits 15..8
// R04 - quad output puts the first byte on data bits 31..24, rest descending
// R05 - one global byte swap reverses byte order on every transfer
// R06 - input stores 1, 2 or 4 sampled bytes per handshake consecutively
// R07 - input writes bits 15..8 or 31..24 into the earliest memory byte
// R08 - pattern compare only on input banks, with or without handshake
// R09 - compare starts at channel 0 and covers exactly the configured width
// R10 - while compare is on and match_trigger is chosen, a match raises interrupt
// R11 - while compare is on, a match raises the alarm flag
// R12 - match may start or stop capture; start collects the programmed count
// R13 - two independent counters, inputs up to 10 MHz, totalize and measure modes
// R14 - edge accumulation is default and counts as soon as it is configured
// R15 - read_then_clear returns the count and then zeroes it
// R16 - halt stops totalizing, arm restarts it
// R17 - counted edge polarity is selectable, rising by default
// R18 - external gate counts only while asserted, at most gate time, then needs arm
// R19 - in measure mode an external gate edge starts the internal gate timer
// R20 - internal gate is default and measurement starts at arm
// R21 - one gated measurement yields frequency, period, duty and pulse width data
// R22 - clock out is 40 MHz timebase over an integer divisor of at least 2
// R23 - requested rate rounds to nearest integer divisor; readback gives rounded value
// R24 - without handshake the comparator samples every cycle, first equal cycle matches
`ifndef DPCC_REGS_VH
`define DPCC_REGS_VH
// register word addresses
`define DPCC_A_BANKCFG   8'h00
`define DPCC_A_MATCHVAL  8'h01
`define DPCC_A_CAPCNT    8'h02
`define DPCC_A_STATUS    8'h03
`define DPCC_A_MEMPTR    8'h04
`define DPCC_A_MEMDATA   8'h05
`define DPCC_A_CNTCFG0   8'h06
`define DPCC_A_CNTCFG1   8'h07
`define DPCC_A_CNTCMD    8'h08
`define DPCC_A_TOTAL0    8'h09
`define DPCC_A_TOTAL1    8'h0a
`define DPCC_A_TOTCLR0   8'h0b
`define DPCC_A_TOTCLR1   8'h0c
`define DPCC_A_PERIOD0   8'h0d
`define DPCC_A_HIGHT0    8'h0e
`define DPCC_A_PERIOD1   8'h0f
`define DPCC_A_HIGHT1    8'h10
`define DPCC_A_CLKRATE   8'h11
`define DPCC_A_CLKDIV    8'h12
// bank config fields
`define DPCC_W_BYTE      2'h0
`define DPCC_W_WORD      2'h1
`define DPCC_W_QUAD      2'h2
`define DPCC_ACT_NONE    2'h0
`define DPCC_ACT_START   2'h1
`define DPCC_ACT_STOP    2'h2
// counter config fields: bit0 measure, bit1 falling, bit2 ext gate
`define DPCC_CF_MEAS     0
`define DPCC_CF_FALL     1
`define DPCC_CF_EXTG     2
// timing
`define DPCC_TB_HZ       40000000
`define DPCC_DIV_MIN     22'h00_0002
`define DPCC_DIV_MAX     22'h3d_0900
`endif

/* rtl/dpcc_top.v */
// pattern compare, buffered byte packing, two counters and clock divider
`timescale 1ns/1ps
`default_nettype none
`include "dpcc_regs.vh"
module dpcc_top
#(
   parameter MEM_AW   = 10,
   parameter CNT_W    = 32
)
(
   input  wire        core_clk_i,
   input  wire        reset_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire [31:0] bank_data_i,
   output reg  [31:0] bank_data_o,
   output wire [31:0] bank_data_oe_o,
   input  wire        hs_in_i,
   output reg         hs_out_o,
   output reg         intr_o,
   output reg         alarm_o,
   input  wire [1:0]  cnt_in_i,
   input  wire [1:0]  gate_in_i,
   input  wire        tb_en_i,
   output reg         clk_out_o
);

////////////////////////////////////////////////////////////////////////////
// configuration registers
reg  [1:0]        width;
reg               dir_in;
reg               swap;
reg               cmp_on;
reg               match_trig;
reg  [1:0]        cap_act;
reg               hs_use;
reg  [31:0]       match_val;
reg  [15:0]       cap_cnt;
reg               trace_valid;
reg  [MEM_AW-1:0] mem_ptr;
reg  [7:0]        mem [0:(1<<MEM_AW)-1];
reg  [2:0]        ccfg [0:1];
reg  [21:0]       div;
reg  [25:0]       rate;
reg               clk_en;

// external inputs: three stages, accept on agreement of stage 2 and 3
reg  [36:0] s1;
reg  [36:0] s2;
reg  [36:0] s3;
reg  [36:0] in_q;
always @(posedge core_clk_i)
begin
   s1 <= {hs_in_i, cnt_in_i, gate_in_i, bank_data_i};
   s2 <= s1;
   s3 <= s2;
end
genvar g;
generate
   for (g = 0; g < 37; g = g + 1)
   begin : g_flt
      always @(posedge core_clk_i)
      begin
         if (reset_i)
            in_q[g] <= 1'b0;
         else if (s2[g] == s3[g])
            in_q[g] <= s3[g];
      end
   end
endgenerate
wire [31:0] din   = in_q[31:0];
wire [1:0]  gin   = in_q[33:32];
wire [1:0]  cin   = in_q[35:34];
wire        hs_q  = in_q[36];
reg         hs_d;
wire        hs_rise = hs_q & ~hs_d;

////////////////////////////////////////////////////////////////////////////
// byte lanes: memory order b0 first; b0 is most significant unless swapped
wire [2:0] nbytes = (width == `DPCC_W_BYTE) ? 3'd1 :
                    (width == `DPCC_W_WORD) ? 3'd2 : 3'd4; // R02 R06
// low data bit of the lane for memory byte k
function [4:0] lane;
   input [1:0] k;
   input [1:0] w;
   input       sw;
   reg   [1:0] pos;
   begin
      pos = (w == `DPCC_W_QUAD) ? (2'd3 - k) :
            (w == `DPCC_W_WORD) ? (2'd1 - k) : 2'd0; // R03 R04 R07
      if (sw)
         pos = (w == `DPCC_W_QUAD) ? k : (w == `DPCC_W_WORD) ? k : 2'd0; // R05
      lane = {pos, 3'b000};
   end
endfunction
wire [31:0] wmask = (width == `DPCC_W_BYTE) ? 32'h0000_00ff :
                    (width == `DPCC_W_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
assign bank_data_oe_o = dir_in ? 32'h0000_0000 : wmask;

////////////////////////////////////////////////////////////////////////////
// pattern compare on bank channel 0 upward, input banks only
wire cmp_eq  = ((din & wmask) == (match_val & wmask));          // R09
wire cmp_smp = hs_use ? hs_rise : 1'b1;                          // R24
wire match   = cmp_on & dir_in & cmp_smp & cmp_eq;              // R08

////////////////////////////////////////////////////////////////////////////
// buffered transfer engine; one sample per handshake edge
reg         run;
reg  [15:0] done;
reg  [MEM_AW-1:0] wptr;
reg  [31:0] assembled;
integer     k;
always @*
begin
   assembled = 32'h0000_0000;
   for (k = 0; k < 4; k = k + 1)
      assembled[8*k +: 8] = mem[wptr + k[MEM_AW-1:0]];
end
wire cap_full = (cap_cnt != 16'h0000) && (done == cap_cnt);
wire sample = run & hs_rise;
integer j;
always @(posedge core_clk_i)
begin
   if (reset_i)
   begin
      run         <= 1'b0;
      done        <= 16'h0000;
      wptr        <= {MEM_AW{1'b0}};
      hs_d        <= 1'b0;
      hs_out_o    <= 1'b0;
      intr_o      <= 1'b0;
      alarm_o     <= 1'b0;
      bank_data_o <= 32'h0000_0000;
   end
   else
   begin
      hs_d     <= hs_q;
      hs_out_o <= sample;
      intr_o   <= match & match_trig;                            // R10
      if (match)
         alarm_o <= 1'b1;                                        // R11
      else if (wr_i && addr_i == `DPCC_A_STATUS && wdata_i[1])
         alarm_o <= 1'b0;
      if (match && cap_act == `DPCC_ACT_START && dir_in)
      begin
         run  <= 1'b1;                                           // R12
         done <= 16'h0000;
      end
      else if (match && cap_act == `DPCC_ACT_STOP)
         run <= 1'b0;                                            // R12
      else if (wr_i && addr_i == `DPCC_A_STATUS)
      begin
         run  <= wdata_i[0] & (dir_in | trace_valid);
         done <= 16'h0000;
         wptr <= {MEM_AW{1'b0}};
      end
      else if (sample)
      begin
         wptr <= wptr + nbytes;                                  // R02 R06
         done <= done + 16'h0001;
         if (!dir_in)
            for (j = 0; j < 4; j = j + 1)
               if (j < nbytes)
                  bank_data_o[lane(j[1:0], width, swap) +: 8] <=
                     assembled[8*j +: 8];                        // R02
         if (dir_in && cap_cnt != 16'h0000 && done + 16'h0001 == cap_cnt)
            run <= 1'b0;                                         // R12
      end
   end
end

// memory: capture writes, or software writes through the pointer port
integer m;
always @(posedge core_clk_i)
begin
   if (sample && dir_in)
   begin
      for (m = 0; m < 4; m = m + 1)
         if (m < nbytes)
            mem[wptr + m[MEM_AW-1:0]] <= din[lane(m[1:0], width, swap) +: 8]; // R07
   end
   else if (wr_i && addr_i == `DPCC_A_MEMDATA)
      mem[mem_ptr] <= wdata_i[7:0];
end

////////////////////////////////////////////////////////////////////////////
// configuration writes
always @(posedge core_clk_i)
begin
   if (reset_i)
   begin
      width <= `DPCC_W_BYTE;
      dir_in <= 1'b1;
      swap <= 1'b0;
      cmp_on <= 1'b0;
      match_trig <= 1'b0;
      cap_act <= `DPCC_ACT_NONE;
      hs_use <= 1'b0;
      match_val <= 32'h0000_0000;
      cap_cnt <= 16'h0000;
      trace_valid <= 1'b0;
      mem_ptr <= {MEM_AW{1'b0}};
      ccfg[0] <= 3'b000;                                         // R14 R17 R20
      ccfg[1] <= 3'b000;
   end
   else if (wr_i)
   begin
      case (addr_i)
         `DPCC_A_BANKCFG:
         begin
            if (wdata_i[1:0] != width || wdata_i[2] != dir_in)
               trace_valid <= 1'b0;                              // R01
            width <= wdata_i[1:0];
            dir_in <= wdata_i[2];
            swap <= wdata_i[3];                                  // R05
            cmp_on <= wdata_i[4];
            match_trig <= wdata_i[5];
            cap_act <= wdata_i[7:6];
            hs_use <= wdata_i[8];
         end
         `DPCC_A_MATCHVAL: match_val <= wdata_i;
         `DPCC_A_CAPCNT:   cap_cnt <= wdata_i[15:0];
         `DPCC_A_MEMPTR:   mem_ptr <= wdata_i[MEM_AW-1:0];
         `DPCC_A_MEMDATA:
         begin
            mem_ptr <= mem_ptr + {{(MEM_AW-1){1'b0}}, 1'b1};
            trace_valid <= 1'b1;
         end
         `DPCC_A_CNTCFG0:  ccfg[0] <= wdata_i[2:0];
         `DPCC_A_CNTCFG1:  ccfg[1] <= wdata_i[2:0];
         default: ;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// two counters: totalize or gated measurement; gate time in core cycles
reg  [CNT_W-1:0] total  [0:1];
reg  [CNT_W-1:0] per    [0:1];
reg  [CNT_W-1:0] hiw    [0:1];
reg  [CNT_W-1:0] gtime;
reg  [1:0]       armed;
generate
   for (g = 0; g < 2; g = g + 1) // R13
   begin : g_cnt
      reg              cd;
      reg              gd;
      reg              meas;
      reg  [CNT_W-1:0] gleft;
      reg  [CNT_W-1:0] pacc;
      reg  [CNT_W-1:0] hacc;
      wire rise = cin[g] & ~cd;
      wire fall = ~cin[g] & cd;
      wire edge_hit = ccfg[g][`DPCC_CF_FALL] ? fall : rise;      // R17
      wire arm  = wr_i && addr_i == `DPCC_A_CNTCMD && wdata_i[2*g];
      wire halt = wr_i && addr_i == `DPCC_A_CNTCMD && wdata_i[2*g+1];
      wire cfgw = wr_i && addr_i == (`DPCC_A_CNTCFG0 + g);
      wire rclr = rd_i && addr_i == (`DPCC_A_TOTCLR0 + g);
      wire gate_ok = ~ccfg[g][`DPCC_CF_EXTG] | gin[g];
      always @(posedge core_clk_i)
      begin
         if (reset_i)
         begin
            cd <= 1'b0; gd <= 1'b0; meas <= 1'b0;
            armed[g] <= 1'b1;                                    // R14
            total[g] <= {CNT_W{1'b0}};
            gleft <= {CNT_W{1'b0}};
            pacc <= {CNT_W{1'b0}}; hacc <= {CNT_W{1'b0}};
            per[g] <= {CNT_W{1'b0}}; hiw[g] <= {CNT_W{1'b0}};
         end
         else
         begin
            cd <= cin[g];
            gd <= gin[g];
            if (cfgw)
            begin
               armed[g] <= ~wdata_i[`DPCC_CF_MEAS];              // R14
               gleft <= gtime;
               meas <= 1'b0;
            end
            else if (halt)
               armed[g] <= 1'b0;                                 // R16
            else if (arm)
            begin
               armed[g] <= 1'b1;                                 // R16
               gleft <= gtime;
               meas <= ~ccfg[g][`DPCC_CF_EXTG];                  // R20
               pacc <= {CNT_W{1'b0}}; hacc <= {CNT_W{1'b0}};
            end
            else if (ccfg[g][`DPCC_CF_MEAS])
            begin
               if (armed[g] && ccfg[g][`DPCC_CF_EXTG] && gin[g] && !gd)
               begin
                  meas <= 1'b1;                                  // R19
                  armed[g] <= 1'b0;
               end
               if (meas)
               begin
                  pacc <= pacc + {{(CNT_W-1){1'b0}}, 1'b1};
                  if (cin[g])
                     hacc <= hacc + {{(CNT_W-1){1'b0}}, 1'b1};
                  gleft <= gleft - {{(CNT_W-1){1'b0}}, 1'b1};
                  if (edge_hit)
                     total[g] <= total[g] + {{(CNT_W-1){1'b0}}, 1'b1};
                  if (gleft == {{(CNT_W-1){1'b0}}, 1'b1})
                  begin
                     meas <= 1'b0;                               // R21
                     per[g] <= pacc;
                     hiw[g] <= hacc;
                  end
               end
            end
            else if (armed[g] && gate_ok)
            begin
               if (edge_hit)
                  total[g] <= total[g] + {{(CNT_W-1){1'b0}}, 1'b1}; // R14
               if (ccfg[g][`DPCC_CF_EXTG])
               begin
                  gleft <= gleft - {{(CNT_W-1){1'b0}}, 1'b1};
                  if (gleft == {{(CNT_W-1){1'b0}}, 1'b1})
                     armed[g] <= 1'b0;                           // R18
               end
            end
            else if (armed[g] && ccfg[g][`DPCC_CF_EXTG] && gd)
               armed[g] <= 1'b0;                                 // R18
            if (rclr)
               total[g] <= {{(CNT_W-1){1'b0}},                   // R15
                  armed[g] & gate_ok & edge_hit & ~ccfg[g][`DPCC_CF_MEAS]};
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////
// clock divider: divisor for the nearest reachable rate, clamped; tick enable
reg  [21:0] dcnt;
wire [31:0] base_hz = `DPCC_TB_HZ;
wire [25:0] req     = wdata_i[25:0];
wire [25:0] qlo     = (req == 26'h000_0000) ? 26'h3ff_ffff :
                      base_hz[25:0] / req;
// rounding the divisor is not rounding the rate: go up when fl + fh > 2 req
wire [79:0] lhs     = base_hz[25:0] * {qlo, 1'b1};                // R23
wire [79:0] rhs     = {req, 1'b0} * qlo * (qlo + 26'h000_0001);
wire [25:0] qrnd    = (lhs <= rhs) ? qlo : qlo + 26'h000_0001;
always @(posedge core_clk_i)
begin
   if (reset_i)
   begin
      div <= `DPCC_DIV_MIN;
      gtime <= {CNT_W{1'b0}};
      clk_en <= 1'b0;
      dcnt <= 22'h00_0000;
      clk_out_o <= 1'b0;
   end
   else
   begin
      if (wr_i && addr_i == `DPCC_A_CLKRATE)
      begin
         clk_en <= wdata_i[31];
         if (qlo >= {4'h0, `DPCC_DIV_MAX})
            div <= `DPCC_DIV_MAX;
         else if (qrnd < {4'h0, `DPCC_DIV_MIN})
            div <= `DPCC_DIV_MIN;                                // R22
         else
            div <= qrnd[21:0];                                   // R23
      end
      if (wr_i && addr_i == `DPCC_A_CLKDIV)
         gtime <= wdata_i[CNT_W-1:0];
      // tb_en_i is the 40 MHz timebase tick
      if (clk_en && tb_en_i)
      begin
         if (dcnt >= div - 22'h00_0001)
            dcnt <= 22'h00_0000;
         else
            dcnt <= dcnt + 22'h00_0001;
         clk_out_o <= (dcnt < (div >> 1));                        // R22
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe; unmapped reads zero
always @(posedge core_clk_i)
begin
   if (reset_i)
      rdata_o <= 32'h0000_0000;
   else if (rd_i)
   begin
      case (addr_i)
         `DPCC_A_BANKCFG:  rdata_o <= {23'h0, hs_use, cap_act, match_trig,
                                       cmp_on, swap, dir_in, width};
         `DPCC_A_MATCHVAL: rdata_o <= match_val;
         `DPCC_A_CAPCNT:   rdata_o <= {16'h0000, cap_cnt};
         `DPCC_A_STATUS:   rdata_o <= {10'h000, done, trace_valid, cap_full,
                                       armed, alarm_o, run};
         `DPCC_A_MEMPTR:   rdata_o <= {{(32-MEM_AW){1'b0}}, mem_ptr};
         `DPCC_A_TOTAL0, `DPCC_A_TOTCLR0: rdata_o <= total[0];
         `DPCC_A_TOTAL1, `DPCC_A_TOTCLR1: rdata_o <= total[1];
         `DPCC_A_PERIOD0:  rdata_o <= per[0];
         `DPCC_A_HIGHT0:   rdata_o <= hiw[0];
         `DPCC_A_PERIOD1:  rdata_o <= per[1];
         `DPCC_A_HIGHT1:   rdata_o <= hiw[1];
         `DPCC_A_CLKRATE:  rdata_o <= `DPCC_TB_HZ / {10'h000, div}; // R23
         `DPCC_A_CLKDIV:   rdata_o <= gtime;
         default:          rdata_o <= 32'h0000_0000;
      endcase
   end
   else
      rdata_o <= 32'h0000_0000;
end

endmodule
`default_nettype wire

/* tb/dpcc_top_asserts.sv */
// bound port checker for the pattern/counter/clock block
`timescale 1ns/1ps
`default_nettype none
`include "dpcc_regs.vh"
module dpcc_top_asserts
(
   input wire logic        core_clk_i,
   input wire logic        reset_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [31:0] bank_data_o,
   input wire logic [31:0] bank_data_oe_o,
   input wire logic        hs_out_o,
   input wire logic        intr_o,
   input wire logic        alarm_o,
   input wire logic        tb_en_i,
   input wire logic        clk_out_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////////
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside the answer cycle");
   a_rd_refuse: assert property (rd_i && addr_i > `DPCC_A_CLKDIV
      |=> rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
   a_oe_width_mask: assert property (bank_data_oe_o inside {32'h0000_0000,
      32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff})
      else $error("output enable is not a bank width mask");
   a_hs_one_pulse: assert property (hs_out_o |=> !hs_out_o)
      else $error("transfer strobe longer than one cycle");
   a_intr_with_alarm: assert property (intr_o |-> ##[0:1] alarm_o)
      else $error("interrupt without alarm");
   // alarm is sticky until software clears it
   a_alarm_sticky: assert property (alarm_o && !(wr_i &&
      addr_i == `DPCC_A_STATUS && wdata_i[1]) |=> alarm_o)
      else $error("alarm dropped without a clear");
   a_reset_vals: assert property ($fell(reset_i) |-> rdata_o == 32'h0000_0000
      && bank_data_o == 32'h0000_0000 && bank_data_oe_o == 32'h0000_0000
      && !hs_out_o && !intr_o && !alarm_o && !clk_out_o)
      else $error("outputs not cleared by reset");
   // without timebase ticks the divided clock cannot move
   a_clk_tick_only: assert property (!tb_en_i [*4] |-> $stable(clk_out_o))
      else $error("clock output moved without timebase ticks");
endmodule
bind dpcc_top dpcc_top_asserts i_chk (.core_clk_i, .reset_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .bank_data_o, .bank_data_oe_o,
   .hs_out_o, .intr_o, .alarm_o, .tb_en_i, .clk_out_o);
`default_nettype wire

/* tb/dpcc_ext_sys.sv */
// model of the external digital system on the bank and counter lines
`timescale 1ns/1ps
`default_nettype none
module dpcc_ext_sys
(
   input  wire logic        core_clk_i,
   output var  logic [31:0] data_o,
   output var  logic        hs_o,
   output var  logic [1:0]  cnt_o,
   output var  logic [1:0]  gate_o
);
   // gates stay low: only internal gating is exercised
   initial
   begin
      data_o = 32'h0000_0000;
      hs_o   = 1'b0;
      cnt_o  = 2'b00;
      gate_o = 2'b00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // levels are held well past the three-flop input filter
   task automatic put(input logic [31:0] v);
      @(posedge core_clk_i);
      data_o <= v;
      hold(8);
   endtask
   task automatic handshake();
      @(posedge core_clk_i);
      hs_o <= 1'b1;
      hold(6);
      hs_o <= 1'b0;
      hold(6);
   endtask
   // five cycles per level keeps the input at 5 MHz
   task automatic cnt_lvl(input int ch, input logic v);
      @(posedge core_clk_i);
      cnt_o[ch] <= v;
      hold(4);
   endtask
   task automatic pulses(input int ch, input int n);
      repeat (n)
      begin
         cnt_lvl(ch, 1'b1);
         cnt_lvl(ch, 1'b0);
      end
   endtask
endmodule
`default_nettype wire

/* tb/dpcc_top_tb.sv */
// self-checking bench for the pattern/counter/clock block
`timescale 1ns/1ps
`default_nettype none
`include "dpcc_regs.vh"
module dpcc_top_tb;
   logic        core_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        tb_en_i = 1'b0;
   logic        tb_hold = 1'b0;
   logic        rd_seen = 1'b0;
   logic        clk_chk = 1'b0, tb_en_d = 1'b0, clk_d = 1'b0;
   wire  [31:0] rdata_o, bank_data_i, bank_data_o, bank_data_oe_o;
   wire  [1:0]  cnt_in_i, gate_in_i;
   wire         hs_in_i, hs_out_o, intr_o, alarm_o, clk_out_o;
   logic [31:0] rdq[$], rmq[$], oq[$], om[$];
   logic [7:0]  mem[8];
   integer      seed = 32'hfbf0_9ae2;
   int          n_errors = 0;
   int          n_checks = 0;
   int          n_intr = 0;
   int          nb;
   logic [31:0] rq[5] = '{32'h01c9_c380, 32'h0131_2d00, 32'h00c6_5d40,
                          32'h00a7_d8c0, 32'h0000_0001};
   logic [31:0] rx[5] = '{32'h0131_2d00, 32'h0131_2d00, 32'h00cb_7355,
                          32'h0098_9680, 32'h0000_000a};
   logic [31:0] pc[4] = '{32'h0000_0035, 32'h0000_0015, 32'h0000_0005,
                          32'h0000_0031};
   logic [31:0] oc[5] = '{32'h0000_0102, 32'h0000_010a, 32'h0000_0109,
                          32'h0000_0101, 32'h0000_0100};
   bit          pi[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
   bit          pa[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   always #10 core_clk_i = ~core_clk_i;
   // 40 MHz ticks average four in five core cycles
   always @(posedge core_clk_i)
      tb_en_i <= !tb_hold && ($random(seed) % 5 != 0);
   dpcc_top i_dpcc_top
   (
      .core_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .bank_data_i, .bank_data_o, .bank_data_oe_o, .hs_in_i, .hs_out_o,
      .intr_o, .alarm_o, .cnt_in_i, .gate_in_i, .tb_en_i, .clk_out_o
   );
   dpcc_ext_sys i_dpcc_ext_sys
   (
      .core_clk_i, .data_o(bank_data_i), .hs_o(hs_in_i), .cnt_o(cnt_in_i),
      .gate_o(gate_in_i)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic mism(input string s);
      n_errors++;
      $display("MISMATCH %0t %s", $time, s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask
   // expected answer is noted when the read is issued
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      rdq.push_back(e);
      rmq.push_back(m);
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
   endtask
   task automatic cmp_rd();
      n_checks++;
      if (rdq.size() == 0)
         mism("unexpected read answer");
      else if (((rdata_o ^ rdq.pop_front()) & rmq.pop_front()) !== 0)
         mism($sformatf("read data %h", rdata_o));
   endtask
   task automatic cmp_out();
      n_checks++;
      if (oq.size() == 0)
         mism("unexpected transfer");
      else if (bank_data_oe_o !== om[0] ||
               ((bank_data_o ^ oq.pop_front()) & om.pop_front()) !== 0)
         mism($sformatf("bank out %h", bank_data_o));
   endtask
   task automatic cmp_intr(input bit e);
      n_checks++;
      if ((n_intr != 0) != e)
         mism("interrupt activity wrong");
   endtask
   task automatic cmp_clk();
      n_checks++;
      if (clk_out_o === clk_d)
         mism("clock output missed a tick");
   endtask
   // packs n memory bytes of transfer t, earliest byte most significant unless swapped
   task automatic expect_out(input int t, input int n, input bit sw);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int j = 0; j < n; j++)
         v = sw ? v | (32'(mem[t*n+j]) << (8*j)) : (v << 8) | mem[t*n+j];
      oq.push_back(v);
      om.push_back(n == 4 ? 32'hffff_ffff : (32'h0000_0001 << (8*n)) - 1);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watcher: read answers one cycle after the strobe, transfers on strobe
   always @(posedge core_clk_i)
   begin
      if (rd_seen)
         cmp_rd();
      rd_seen = rd_i;
      if (hs_out_o === 1'b1)
         cmp_out();
      if (intr_o === 1'b1)
         n_intr++;
      // at 20 MHz every timebase tick flips the output
      if (clk_chk && tb_en_d)
         cmp_clk();
      tb_en_d = tb_en_i;
      clk_d = clk_out_o;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(8'h3f, 32'h0000_0000, 32'hffff_ffff);
      // requested rates come back rounded to an integer divisor
      foreach (rq[i])
      begin
         wr(`DPCC_A_CLKRATE, 32'h8000_0000 | rq[i]);
         rd(`DPCC_A_CLKRATE, rx[i], 32'h03ff_ffff);
      end
      wr(`DPCC_A_CLKRATE, 32'h8131_2d00);
      repeat (8) @(posedge core_clk_i);
      clk_chk <= 1'b1;
      repeat (40) @(posedge core_clk_i);
      clk_chk <= 1'b0;
      // totalizers: default running, clear on read, halt and arm, slope
      wr(`DPCC_A_CNTCFG1, 32'h0000_0002);
      i_dpcc_ext_sys.pulses(0, 5);
      i_dpcc_ext_sys.hold(4);
      rd(`DPCC_A_TOTCLR0, 32'h0000_0005, 32'hffff_ffff);
      rd(`DPCC_A_TOTAL0, 32'h0000_0000, 32'hffff_ffff);
      wr(`DPCC_A_CNTCMD, 32'h0000_0002);
      i_dpcc_ext_sys.pulses(0, 3);
      rd(`DPCC_A_TOTAL0, 32'h0000_0000, 32'hffff_ffff);
      wr(`DPCC_A_CNTCMD, 32'h0000_0001);
      i_dpcc_ext_sys.pulses(0, 2);
      i_dpcc_ext_sys.hold(4);
      rd(`DPCC_A_TOTAL0, 32'h0000_0002, 32'hffff_ffff);
      i_dpcc_ext_sys.cnt_lvl(1, 1'b1);
      i_dpcc_ext_sys.hold(4);
      rd(`DPCC_A_TOTAL1, 32'h0000_0000, 32'hffff_ffff);
      i_dpcc_ext_sys.cnt_lvl(1, 1'b0);
      i_dpcc_ext_sys.hold(4);
      rd(`DPCC_A_TOTAL1, 32'h0000_0001, 32'hffff_ffff);
      // pattern compare: random bits above the word width must not matter
      wr(`DPCC_A_MATCHVAL, 32'h0000_f00f);
      foreach (pc[i])
      begin
         wr(`DPCC_A_BANKCFG, pc[i]);
         i_dpcc_ext_sys.put(($random(seed) & 32'hffff_0000) | 32'h0000_0ff0);
         wr(`DPCC_A_STATUS, 32'h0000_0002);
         n_intr = 0;
         i_dpcc_ext_sys.put(($random(seed) & 32'hffff_0000) | 32'h0000_f00f);
         cmp_intr(pi[i]);
         rd(`DPCC_A_STATUS, {30'h0, pa[i], 1'b0}, 32'h2);
      end
      // buffered output in every width, quad and word width also with byte swap
      foreach (oc[i])
      begin
         wr(`DPCC_A_BANKCFG, oc[i]);
         wr(`DPCC_A_MEMPTR, 32'h0000_0000);
         for (int k = 0; k < 8; k++)
         begin
            mem[k] = 8'($random(seed));
            wr(`DPCC_A_MEMDATA, {24'h00_0000, mem[k]});
         end
         rd(`DPCC_A_STATUS, 32'h0000_0020, 32'h0000_0020);
         wr(`DPCC_A_STATUS, 32'h0000_0001);
         nb = 1 << oc[i][1:0];
         for (int t = 0; t < 8 / nb; t++)
         begin
            expect_out(t, nb, oc[i][3]);
            i_dpcc_ext_sys.handshake();
         end
         wr(`DPCC_A_STATUS, 32'h0000_0000);
      end
      wr(`DPCC_A_BANKCFG, 32'h0000_0005);
      rd(`DPCC_A_STATUS, 32'h0000_0000, 32'h0000_0020);
      tb_hold <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      if (rdq.size() + oq.size() != 0)
         mism("results missing");
      finish_test();
   end
   // watchdog far above the fewer than a thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      mism("watchdog expired");
      finish_test();
   end
endmodule
`default_nettype wire
